// ===== core/bcp_path_ctrl.sv
// B-channel path control between the interchip link and the loop
`timescale 1ns/1ps
`default_nettype none

module bcp_async_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input  wire logic             wclk,
    input  wire logic             wrst_n,
    input  wire logic             wvalid,
    output logic                  wready,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             rclk,
    input  wire logic             rrst_n,
    output logic                  rvalid,
    input  wire logic             rready,
    output logic      [WIDTH-1:0] rdata
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin_q;
    logic [AW:0]      wgray_q;
    logic [AW:0]      rbin_q;
    logic [AW:0]      rgray_q;
    logic [AW:0]      rg_w1_q;
    logic [AW:0]      rg_w2_q;
    logic [AW:0]      wg_r1_q;
    logic [AW:0]      wg_r2_q;
    logic [AW:0]      wbin_d;
    logic [AW:0]      rbin_d;

    assign wready = wgray_q != {~rg_w2_q[AW:AW-1], rg_w2_q[AW-2:0]};
    assign rvalid = rgray_q != wg_r2_q;
    assign rdata  = mem[rbin_q[AW-1:0]];
    assign wbin_d = wbin_q + (AW+1)'(1);
    assign rbin_d = rbin_q + (AW+1)'(1);

    always_ff @(posedge wclk) begin
        if (wvalid && wready) begin
            mem[wbin_q[AW-1:0]] <= wdata;
        end
    end

    always_ff @(posedge wclk or negedge wrst_n) begin
        if (!wrst_n) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg_w1_q <= '0;
            rg_w2_q <= '0;
        end else begin
            rg_w1_q <= rgray_q;
            rg_w2_q <= rg_w1_q;
            if (wvalid && wready) begin
                wbin_q  <= wbin_d;
                wgray_q <= wbin_d ^ (wbin_d >> 1);
            end
        end
    end

    always_ff @(posedge rclk or negedge rrst_n) begin
        if (!rrst_n) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            wg_r1_q <= '0;
            wg_r2_q <= '0;
        end else begin
            wg_r1_q <= wgray_q;
            wg_r2_q <= wg_r1_q;
            if (rvalid && rready) begin
                rbin_q  <= rbin_d;
                rgray_q <= rbin_d ^ (rbin_d >> 1);
            end
        end
    end
endmodule : bcp_async_fifo

module bcp_path_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        sw_reset,
    input  wire logic        network_side_mode,
    input  wire logic [2:0]  nib_addr,
    input  wire logic        nib_wr,
    input  wire logic [3:0]  nib_wdata,
    output logic      [3:0]  nib_rdata,
    input  wire logic        m_channel_hunt_bit,
    input  wire logic        a_channel_hunt_bit,
    output logic             loop_tx_valid,
    input  wire logic        loop_tx_ready,
    output logic      [7:0]  loop_tx_b1,
    output logic      [7:0]  loop_tx_b2,
    output logic      [1:0]  loop_tx_d,
    input  wire logic        loop_rx_valid,
    output logic             loop_rx_ready,
    input  wire logic [7:0]  loop_rx_b1,
    input  wire logic [7:0]  loop_rx_b2,
    input  wire logic [1:0]  loop_rx_d,
    input  wire logic        clk_link,
    input  wire logic        link_fsync,
    input  wire logic        link_receive_pin,
    output logic             link_transmit_pin,
    output logic             link_transmit_oe,
    output logic             m_channel_fifo_port_load,
    output logic      [7:0]  m_channel_fifo_port_data,
    output logic             a_channel_fifo_port_load,
    output logic      [7:0]  a_channel_fifo_port_data
);
    localparam int FRAME_BITS = bcp_pkg::FRAME_BITS;

    logic [3:0]      bloop_q;
    logic [3:0]      lpath_q;
    logic [3:0]      rdata_q;
    // Link domain
    logic            lrst1_q;
    logic            lrst_n;
    logic [10:0]     ctl1_q;
    logic [10:0]     ctl_q;
    logic [1:0]      rx_sync_q;
    logic [1:0]      fs_sync_q;
    logic [5:0]      cnt_q;
    logic [FRAME_BITS-2:0] rx_sh_q;
    logic [FRAME_BITS-1:0] word;
    logic            frame_done;
    logic [bcp_pkg::BW-1:0] tx_word_q;
    logic [bcp_pkg::BW-1:0] dn_word;
    logic [bcp_pkg::BW-1:0] up_word;
    logic [bcp_pkg::BW-1:0] up_rdata;
    logic [bcp_pkg::BW-1:0] rx_bd;
    logic            up_rvalid;
    logic            dn_wready;
    logic            nt;
    logic            pass1;
    logic            pass2;
    logic            lb;
    logic            xchg;
    logic [7:0]      l1;
    logic [7:0]      l2;
    logic [7:0]      s1;
    logic [7:0]      s2;
    logic [7:0]      m_byte;
    logic [7:0]      a_byte;
    logic [bcp_pkg::BW-1:0] dn_rdata;

    // Register file, sys domain
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bloop_q <= bcp_pkg::NIB_RST;
        end else if (sw_reset) begin
            bloop_q <= bcp_pkg::NIB_RST;
        end else if (nib_wr && nib_addr == bcp_pkg::ADDR_BLOOP) begin
            bloop_q <= nib_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lpath_q <= bcp_pkg::NIB_RST;
        end else if (sw_reset) begin
            lpath_q <= bcp_pkg::NIB_RST;
        end else if (nib_wr && nib_addr == bcp_pkg::ADDR_LPATH) begin
            lpath_q <= nib_wdata;
        end
    end

    // Read data lags the address by one clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else begin
            unique case (nib_addr)
                bcp_pkg::ADDR_BLOOP: rdata_q <= bloop_q;
                bcp_pkg::ADDR_LPATH: rdata_q <= lpath_q;
                default:             rdata_q <= '0;
            endcase
        end
    end
    assign nib_rdata = rdata_q;

    // Link reset: asserted at once, released on the link clock
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            lrst1_q <= 1'b0;
            lrst_n  <= 1'b0;
        end else begin
            lrst1_q <= 1'b1;
            lrst_n  <= lrst1_q;
        end
    end

    // Quasi-static controls; a change may straddle one frame
    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            ctl1_q <= '0;
            ctl_q  <= '0;
        end else begin
            ctl1_q <= {a_channel_hunt_bit, m_channel_hunt_bit,
                       network_side_mode, lpath_q, bloop_q};
            ctl_q  <= ctl1_q;
        end
    end

    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_sync_q <= '0;
            fs_sync_q <= '0;
        end else begin
            rx_sync_q <= {rx_sync_q[0], link_receive_pin};
            fs_sync_q <= {fs_sync_q[0], link_fsync};
        end
    end

    // Bit counter; frame sync marks bit 0
    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            cnt_q <= bcp_pkg::FRAME_LAST;
        end else if (fs_sync_q[1]) begin
            cnt_q <= '0;
        end else if (cnt_q != bcp_pkg::FRAME_LAST) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            rx_sh_q <= '0;
        end else begin
            rx_sh_q <= {rx_sh_q[FRAME_BITS-3:0], rx_sync_q[1]};
        end
    end

    assign word       = {rx_sh_q, rx_sync_q[1]};
    assign frame_done = (cnt_q == bcp_pkg::FRAME_LAST - 6'h01);
    assign m_byte     = word[bcp_pkg::M_LSB +: 8];
    assign a_byte     = word[bcp_pkg::A_LSB +: 8];
    assign rx_bd      = word[bcp_pkg::D_LSB - bcp_pkg::WD_LSB +: bcp_pkg::BW];

    assign nt    = ctl_q[8];
    assign lb    = ctl_q[4 + bcp_pkg::LP_LOOPBACK];
    assign xchg  = ctl_q[4 + bcp_pkg::LP_EXCHANGE] && !lb;
    // Idle bit on network side, enable bit on terminal side
    assign pass1 = nt ? !ctl_q[bcp_pkg::BL_B1_SEL]
                      : ctl_q[bcp_pkg::BL_B1_SEL];
    assign pass2 = nt ? !ctl_q[bcp_pkg::BL_B2_SEL]
                      : ctl_q[bcp_pkg::BL_B2_SEL];

    // Link to loop: invert per link slot, swap, then idle per loop slot
    always_comb begin
        l1 = word[bcp_pkg::B1_LSB +: 8]
             ^ {8{ctl_q[bcp_pkg::BL_INV_B1]}};
        l2 = word[bcp_pkg::B2_LSB +: 8]
             ^ {8{ctl_q[bcp_pkg::BL_INV_B2]}};
        s1 = xchg ? l2 : l1;
        s2 = xchg ? l1 : l2;
        if (lb) begin
            dn_word = bcp_pkg::IDLE_WORD;
        end else begin
            dn_word = {pass1 ? s1 : bcp_pkg::IDLE_B,
                       word[bcp_pkg::D_LSB +: 2],
                       pass2 ? s2 : bcp_pkg::IDLE_B};
        end
    end

    // Loop to link: swap to link slots, then invert per link slot
    always_comb begin
        if (xchg) begin
            up_word = {up_rdata[bcp_pkg::WB2_LSB +: 8],
                       up_rdata[bcp_pkg::WD_LSB +: 2],
                       up_rdata[bcp_pkg::WB1_LSB +: 8]};
        end else begin
            up_word = up_rdata;
        end
        up_word[bcp_pkg::WB1_LSB +: 8] = up_word[bcp_pkg::WB1_LSB +: 8]
            ^ {8{ctl_q[bcp_pkg::BL_INV_B1]}};
        up_word[bcp_pkg::WB2_LSB +: 8] = up_word[bcp_pkg::WB2_LSB +: 8]
            ^ {8{ctl_q[bcp_pkg::BL_INV_B2]}};
    end

    // Next frame's transmit word; the received 2B+D in loopback, else ones when the loop has nothing ready
    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            tx_word_q <= bcp_pkg::IDLE_WORD;
        end else if (frame_done) begin
            if (lb) begin
                tx_word_q <= rx_bd;
            end else if (up_rvalid) begin
                tx_word_q <= up_word;
            end else begin
                tx_word_q <= bcp_pkg::IDLE_WORD;
            end
        end
    end

    // Transmit pin follows the counter one link clock late
    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            link_transmit_pin <= 1'b1;
            link_transmit_oe  <= 1'b0;
        end else begin
            link_transmit_oe  <= (cnt_q <= bcp_pkg::BD_LAST);
            link_transmit_pin <= (cnt_q <= bcp_pkg::BD_LAST)
                ? tx_word_q[bcp_pkg::BD_LAST[4:0] - cnt_q[4:0]] : 1'b1;
        end
    end

    // Hunt bit set: an all-ones byte is taken as no message
    always_ff @(posedge clk_link or negedge lrst_n) begin
        if (!lrst_n) begin
            m_channel_fifo_port_load <= 1'b0;
            m_channel_fifo_port_data <= '0;
            a_channel_fifo_port_load <= 1'b0;
            a_channel_fifo_port_data <= '0;
        end else begin
            m_channel_fifo_port_load <= frame_done
                && ctl_q[4 + bcp_pkg::LP_M_ACT]
                && (!ctl_q[9] || m_byte != bcp_pkg::IDLE_B);
            a_channel_fifo_port_load <= frame_done
                && ctl_q[4 + bcp_pkg::LP_A_ACT]
                && (!ctl_q[10] || a_byte != bcp_pkg::IDLE_B);
            if (frame_done) begin
                m_channel_fifo_port_data <= m_byte;
                a_channel_fifo_port_data <= a_byte;
            end
        end
    end

    // A full buffer drops the frame rather than stalling the link
    bcp_async_fifo #(.WIDTH(bcp_pkg::BW), .DEPTH(bcp_pkg::FIFO_DEPTH)) u_dn (
        .wclk   (clk_link),
        .wrst_n (lrst_n),
        .wvalid (frame_done),
        .wready (dn_wready),
        .wdata  (dn_word),
        .rclk   (clk_sys),
        .rrst_n (arst_n),
        .rvalid (loop_tx_valid),
        .rready (loop_tx_ready),
        .rdata  (dn_rdata)
    );
    assign loop_tx_b1 = dn_rdata[bcp_pkg::WB1_LSB +: 8];
    assign loop_tx_d  = dn_rdata[bcp_pkg::WD_LSB +: 2];
    assign loop_tx_b2 = dn_rdata[bcp_pkg::WB2_LSB +: 8];

    bcp_async_fifo #(.WIDTH(bcp_pkg::BW), .DEPTH(bcp_pkg::FIFO_DEPTH)) u_up (
        .wclk   (clk_sys),
        .wrst_n (arst_n),
        .wvalid (loop_rx_valid),
        .wready (loop_rx_ready),
        .wdata  ({loop_rx_b1, loop_rx_d, loop_rx_b2}),
        .rclk   (clk_link),
        .rrst_n (lrst_n),
        .rvalid (up_rvalid),
        .rready (frame_done && !lb),
        .rdata  (up_rdata)
    );

    a_reg_swreset: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sw_reset |=> bloop_q == bcp_pkg::NIB_RST
                     && lpath_q == bcp_pkg::NIB_RST)
        else $error("nibbles not cleared by soft reset");
    a_reg_readback: assert property (@(posedge clk_sys) disable iff (!arst_n)
        nib_wr && nib_addr == bcp_pkg::ADDR_LPATH && !sw_reset
        ##1 nib_addr == bcp_pkg::ADDR_LPATH && !nib_wr && !sw_reset
        |=> nib_rdata == $past(nib_wdata, 2))
        else $error("link path nibble readback wrong");
    a_idle_b1_nt: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && nt && ctl_q[bcp_pkg::BL_B1_SEL]
        |-> dn_word[bcp_pkg::WB1_LSB +: 8] == bcp_pkg::IDLE_B)
        else $error("B1 not idle in network mode");
    a_te_b2_off: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && !nt && !ctl_q[bcp_pkg::BL_B2_SEL]
        |-> dn_word[bcp_pkg::WB2_LSB +: 8] == bcp_pkg::IDLE_B)
        else $error("B2 not idle while disabled");
    a_inv_b1_dn: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && !lb && !xchg && pass1 && ctl_q[bcp_pkg::BL_INV_B1]
        |-> dn_word[bcp_pkg::WB1_LSB +: 8]
            == ~word[bcp_pkg::B1_LSB +: 8])
        else $error("B1 not inverted toward loop");
    a_xchg_dn: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && xchg && pass2 && !ctl_q[bcp_pkg::BL_INV_B1]
        |-> dn_word[bcp_pkg::WB2_LSB +: 8]
            == word[bcp_pkg::B1_LSB +: 8])
        else $error("link B1 not sent in loop B2");
    a_lb_idle: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && lb |-> dn_word == bcp_pkg::IDLE_WORD)
        else $error("loop not idle during loopback");
    a_lb_return: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && lb |=> tx_word_q == $past(rx_bd))
        else $error("loopback word not returned");
    a_up_invert: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && !lb && up_rvalid && !xchg
        && ctl_q[bcp_pkg::BL_INV_B2]
        |=> tx_word_q[7:0] == ~$past(up_rdata[7:0]))
        else $error("B2 not inverted toward link");
    a_m_gate: assert property (@(posedge clk_link) disable iff (!lrst_n)
        m_channel_fifo_port_load
        |-> $past(ctl_q[4 + bcp_pkg::LP_M_ACT]))
        else $error("M byte loaded while inactive");
    a_a_gate: assert property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && !ctl_q[4 + bcp_pkg::LP_A_ACT]
        |=> !a_channel_fifo_port_load)
        else $error("A byte loaded while inactive");

    c_loopback: cover property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && lb ##[1:40] frame_done && lb);
    c_exchange: cover property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && xchg && up_rvalid);
    c_m_load: cover property (@(posedge clk_link) disable iff (!lrst_n)
        m_channel_fifo_port_load && ctl_q[9]);
    c_dn_full: cover property (@(posedge clk_link) disable iff (!lrst_n)
        frame_done && !dn_wready);
endmodule : bcp_path_ctrl

`default_nettype wire

// ===== shared/bcp_pkg.sv
// Constants for the B-channel path control block
`default_nettype none
package bcp_pkg;
    // Nibble register addresses
    localparam logic [2:0] ADDR_BLOOP = 3'h5;
    localparam logic [2:0] ADDR_LPATH = 3'h6;
    localparam logic [3:0] NIB_RST    = 4'h0;
    // bchannel_loop_control fields
    localparam int BL_B1_SEL = 3;
    localparam int BL_B2_SEL = 2;
    localparam int BL_INV_B1 = 1;
    localparam int BL_INV_B2 = 0;
    // link_path_control fields
    localparam int LP_LOOPBACK = 3;
    localparam int LP_M_ACT    = 2;
    localparam int LP_A_ACT    = 1;
    localparam int LP_EXCHANGE = 0;
    // Link frame: B1, D, B2, M, A in arrival order, MSB first
    localparam int          FRAME_BITS = 34;
    localparam logic [5:0]  FRAME_LAST = 6'h21;
    localparam int          B1_LSB     = 26;
    localparam int          D_LSB      = 24;
    localparam int          B2_LSB     = 16;
    localparam int          M_LSB      = 8;
    localparam int          A_LSB      = 0;
    // Buffered 2B+D word {b1, d, b2}
    localparam int          BW         = 18;
    localparam logic [5:0]  BD_LAST    = 6'h11;
    localparam int          WB1_LSB    = 10;
    localparam int          WD_LSB     = 8;
    localparam int          WB2_LSB    = 0;
    localparam logic [7:0]  IDLE_B     = 8'hFF;
    localparam logic [1:0]  IDLE_D     = 2'h3;
    localparam logic [17:0] IDLE_WORD  = 18'h3FFFF;
    localparam int          FIFO_DEPTH = 16;
endpackage : bcp_pkg
`default_nettype wire

// ===== dv/bcp_link_partner.sv
// Link-side codec model: sends framed data, captures returned slots
`timescale 1ns/1ps
`default_nettype none

module bcp_link_partner (
    input  wire logic        clk_link,
    input  wire logic        arst_n,
    input  wire logic [33:0] frame_in,
    output logic             link_fsync,
    output logic             link_receive_pin,
    input  wire logic        link_transmit_pin,
    input  wire logic        link_transmit_oe,
    output logic      [17:0] rx_word
);
    logic [5:0]  bit_q;
    logic [2:0]  hold_q;
    logic [33:0] cur_q;
    logic [17:0] sh_q;
    logic        oe_q;

    // Frames run back to back, so the receive pin is never left floating
    always @(negedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            hold_q           <= 3'h4;
            bit_q            <= 6'h00;
            cur_q            <= '1;
            link_fsync       <= 1'b0;
            link_receive_pin <= 1'b1;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else begin
            link_fsync       <= (bit_q == 6'h00);
            link_receive_pin <= (bit_q == 6'h00) ? frame_in[33]
                                                 : cur_q[6'h21 - bit_q];
            if (bit_q == 6'h00)
                cur_q <= frame_in;
            bit_q <= (bit_q == 6'h21) ? 6'h00 : bit_q + 6'h01;
        end
    end

    // Pin launches on the rising edge, so sample it mid-bit
    always @(negedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            sh_q    <= '0;
            oe_q    <= 1'b0;
            rx_word <= '0;
        end else begin
            oe_q <= link_transmit_oe;
            if (link_transmit_oe === 1'b1)
                sh_q <= {sh_q[16:0], link_transmit_pin};
            if (oe_q && link_transmit_oe !== 1'b1)
                rx_word <= sh_q;
        end
    end
endmodule : bcp_link_partner
`default_nettype wire

// ===== dv/bcp_path_ctrl_test.sv
// Self-checking bench for the B-channel path control block
`timescale 1ns/1ps
`default_nettype none

module bcp_path_ctrl_test;
    localparam logic [10:0] CORNER [6] = '{11'h400, 11'h01B, 11'h7C4,
                                          11'h3C4, 11'h2E4, 11'h51E};
    logic        clk_sys, clk_link, arst_n, sw_reset, nt, nib_wr;
    logic [2:0]  nib_addr;
    logic [3:0]  nib_wdata, nib_rdata, c5, c6;
    logic        m_hunt, a_hunt, loop_tx_valid, loop_tx_ready;
    logic        loop_rx_valid, loop_rx_ready, link_fsync, rx_pin;
    logic [7:0]  tx_b1, tx_b2, m_data, a_data, m_last, a_last;
    logic [1:0]  tx_d;
    logic        tx_pin, tx_oe, m_load, a_load, chk_on, saw_full;
    logic [33:0] frame;
    logic [17:0] rx_word, loop_word, exp_tx, tx_word;
    int          error_cnt, n_compared, n_tx, m_cnt, a_cnt, snap;

    assign tx_word = {tx_b1, tx_d, tx_b2};

    bcp_path_ctrl bcp_path_ctrl_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .sw_reset(sw_reset),
        .network_side_mode(nt), .nib_addr(nib_addr), .nib_wr(nib_wr),
        .nib_wdata(nib_wdata), .nib_rdata(nib_rdata),
        .m_channel_hunt_bit(m_hunt), .a_channel_hunt_bit(a_hunt),
        .loop_tx_valid(loop_tx_valid), .loop_tx_ready(loop_tx_ready),
        .loop_tx_b1(tx_b1), .loop_tx_b2(tx_b2), .loop_tx_d(tx_d),
        .loop_rx_valid(loop_rx_valid), .loop_rx_ready(loop_rx_ready),
        .loop_rx_b1(loop_word[17:10]), .loop_rx_b2(loop_word[7:0]),
        .loop_rx_d(loop_word[9:8]), .clk_link(clk_link),
        .link_fsync(link_fsync), .link_receive_pin(rx_pin),
        .link_transmit_pin(tx_pin), .link_transmit_oe(tx_oe),
        .m_channel_fifo_port_load(m_load), .m_channel_fifo_port_data(m_data),
        .a_channel_fifo_port_load(a_load), .a_channel_fifo_port_data(a_data)
    );

    bcp_link_partner bcp_link_partner_inst (
        .clk_link(clk_link), .arst_n(arst_n), .frame_in(frame),
        .link_fsync(link_fsync), .link_receive_pin(rx_pin),
        .link_transmit_pin(tx_pin), .link_transmit_oe(tx_oe),
        .rx_word(rx_word)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Odd offset keeps the link clock out of phase with the system clock
    initial begin
        clk_link = 1'b0;
        #7;
        forever #40 clk_link = ~clk_link;
    end

    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end

    task automatic check(input string what, input logic [17:0] seen,
                         input logic [17:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    function automatic logic [17:0] exp_loop();
        logic [7:0] i1, i2, s1, s2;
        i1 = frame[33:26] ^ {8{c5[1]}};
        i2 = frame[23:16] ^ {8{c5[0]}};
        s1 = c6[0] ? i2 : i1;
        s2 = c6[0] ? i1 : i2;
        if (c6[3])
            return bcp_pkg::IDLE_WORD;
        return {(c5[3] == nt) ? 8'hFF : s1, frame[25:24],
                (c5[2] == nt) ? 8'hFF : s2};
    endfunction : exp_loop

    function automatic logic [17:0] exp_link(input logic have);
        logic [7:0] o1, o2;
        o1 = (c6[0] ? loop_word[7:0] : loop_word[17:10]) ^ {8{c5[1]}};
        o2 = (c6[0] ? loop_word[17:10] : loop_word[7:0]) ^ {8{c5[0]}};
        if (c6[3])
            return frame[33:16];
        if (!have)
            return bcp_pkg::IDLE_WORD;
        return {o1, loop_word[9:8], o2};
    endfunction : exp_link

    task automatic wr(input logic [2:0] a, input logic [3:0] d);
        @(negedge clk_sys);
        nib_addr  = a;
        nib_wdata = d;
        nib_wr    = 1'b1;
        @(negedge clk_sys);
        nib_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [3:0] e,
                      input string w);
        @(negedge clk_sys);
        nib_addr = a;
        repeat (2) @(negedge clk_sys);
        check(w, {14'h0, nib_rdata}, {14'h0, e});
    endtask : rd

    // One link frame is 34 bits of 80 ns, close to 109 system cycles
    task automatic frames(input int n);
        repeat (n * 109) @(negedge clk_sys);
    endtask : frames

    task automatic path_test(input int i);
        logic mx, ax;
        wr(3'h5, c5);
        wr(3'h6, c6);
        exp_tx = exp_loop();
        // Long settle: stale words in the 16-deep loop buffer must drain
        frames(18);
        m_cnt  = 0;
        a_cnt  = 0;
        chk_on = 1'b1;
        frames(3);
        chk_on = 1'b0;
        mx = c6[2] && !(m_hunt && frame[15:8] == 8'hFF);
        ax = c6[1] && !(a_hunt && frame[7:0] == 8'hFF);
        check("link tx", rx_word, exp_link(1'b1));
        check("m loads", 18'(m_cnt != 0), 18'(mx));
        check("a loads", 18'(a_cnt != 0), 18'(ax));
        if (mx)
            check("m byte", 18'(m_last), 18'(frame[15:8]));
        if (ax)
            check("a byte", 18'(a_last), 18'(frame[7:0]));
        rd(3'h6, c6, "path ctl");
        $display("path test %0d done", i);
    endtask : path_test

    always @(posedge clk_sys) begin
        if (loop_tx_valid === 1'b1 && loop_tx_ready) begin
            n_tx <= n_tx + 1;
            if (chk_on)
                check("loop tx", tx_word, exp_tx);
        end
        if (loop_rx_valid && loop_rx_ready === 1'b0 && arst_n)
            saw_full <= 1'b1;
    end

    always @(posedge clk_link) begin
        if (m_load === 1'b1) begin
            m_cnt++;
            m_last = m_data;
        end
        if (a_load === 1'b1) begin
            a_cnt++;
            a_last = a_data;
        end
    end

    initial begin
        {arst_n, sw_reset, nt, nib_wr, m_hunt, a_hunt, chk_on} = '0;
        {nib_addr, nib_wdata, frame, exp_tx, c5, c6} = '0;
        {loop_tx_ready, loop_rx_valid, saw_full} = '0;
        error_cnt  = 0;
        n_compared = 0;
        n_tx       = 0;
        void'($urandom(32'hBCCE));
        loop_word = 18'($urandom);
        repeat (5) @(posedge clk_link);
        @(negedge clk_sys);
        arst_n        = 1'b1;
        loop_tx_ready = 1'b1;
        loop_rx_valid = 1'b1;
        rd(3'h5, 4'h0, "loop ctl reset");
        rd(3'h6, 4'h0, "path ctl reset");
        for (int i = 0; i < 8; i++) begin
            c5 = 4'($urandom);
            wr(3'h5 + 3'(i & 1), c5);
            rd(3'h5 + 3'(i & 1), c5, "readback");
        end
        wr(3'h7, 4'hF);
        rd(3'h7, 4'h0, "unmapped");
        wr(3'h5, 4'hA);
        wr(3'h6, 4'hF);
        @(negedge clk_sys);
        sw_reset = 1'b1;
        @(negedge clk_sys);
        sw_reset = 1'b0;
        rd(3'h5, 4'h0, "loop ctl soft reset");
        rd(3'h6, 4'h0, "path ctl soft reset");
        $display("register tests done");
        for (int i = 0; i < 15; i++) begin
            {nt, c5, c6, m_hunt, a_hunt} = (i < 6) ? CORNER[i]
                                                   : 11'($urandom);
            if (i == 14)
                {nt, c5, c6, m_hunt, a_hunt} = CORNER[0];
            frame = {$urandom, 2'($urandom)};
            if (i == 1)
                frame[15:8] = 8'hFF;
            path_test(i);
        end
        // Modulator stalls: loop tx buffer fills, then drains
        chk_on        = 1'b1;
        loop_tx_ready = 1'b0;
        frames(20);
        check("tx held", 18'(loop_tx_valid), 18'h1);
        snap          = n_tx;
        loop_tx_ready = 1'b1;
        repeat (60) @(negedge clk_sys);
        check("tx drained", 18'(n_tx - snap >= 16), 18'h1);
        chk_on = 1'b0;
        check("rx full seen", 18'(saw_full), 18'h1);
        for (int k = 0; k < 300 && loop_rx_ready !== 1'b1; k++)
            @(negedge clk_sys);
        check("rx ready back", 18'(loop_rx_ready), 18'h1);
        @(negedge clk_sys);
        loop_rx_valid = 1'b0;
        frames(20);
        check("link tx empty", rx_word, exp_link(1'b0));
        // Mid-run hardware reset must clear written nibbles again
        wr(3'h5, 4'hF);
        wr(3'h6, 4'hF);
        @(negedge clk_sys);
        arst_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        arst_n = 1'b1;
        rd(3'h5, 4'h0, "loop ctl rerun reset");
        rd(3'h6, 4'h0, "path ctl rerun reset");
        $display("buffer tests done");
        final_report();
    end
endmodule : bcp_path_ctrl_test
`default_nettype wire
